// ---- core/triac_drv_pkg.sv ----
package triac_drv_pkg;
   // register byte offsets on the register bus
   localparam logic [7:0] ADDR_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_WIDTH_HIGH = 8'h04;
   localparam logic [7:0] ADDR_WIDTH_LOW = 8'h08;
   localparam logic [7:0] ADDR_IRQ_CONFIG = 8'h0c;
   localparam logic [7:0] ADDR_LEVEL = 8'h10;
   localparam logic [7:0] ADDR_PRESCALER = 8'h14;
   localparam logic [7:0] ADDR_STATUS = 8'h18;
   // reset values
   localparam logic [7:0] RST_CONTROL = 8'h00;
   localparam logic [7:0] RST_WIDTH = 8'h00;
   localparam logic [7:0] RST_IRQ_CONFIG = 8'h00;
   localparam logic [7:0] RST_LEVEL = 8'h00;
   localparam logic [15:0] RST_PRESCALER = 16'h0000;
   // control field positions
   localparam int POL_BIT = 0;
   localparam int MODE_LO = 2;
   localparam int MODE_HI = 3;
   localparam int CKSEL_BIT = 4;
   localparam int RUN_BIT = 5;
   localparam int SSEL_BIT = 6;
   localparam int EN_BIT = 7;
   // irq_config field position
   localparam int IRQ_SEL_LO = 3;
   localparam int IRQ_SEL_HI = 5;
   // mode encodings
   localparam logic [1:0] MODE_PWM = 2'h0;
   localparam logic [1:0] MODE_BURST = 2'h1;
   // interrupt source encodings
   localparam logic [2:0] IRQ_NONE = 3'h0;
   localparam logic [2:0] IRQ_RISE = 3'h1;
   localparam logic [2:0] IRQ_FALL = 3'h2;
   localparam logic [2:0] IRQ_BOTH = 3'h3;
   localparam logic [2:0] IRQ_PULSE = 3'h4;
   // burst window length in prescaler periods, last count value
   localparam logic [7:0] WIN_LAST = 8'hfe;
   // phase-mode train: 8 pulses, 16 half periods
   localparam logic [3:0] TRAIN_LAST = 4'hf;
   // timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int IRQ_PULSE_NS = 50;
   localparam logic [1:0] IRQ_PULSE_CYC = 2'((IRQ_PULSE_NS / CLK_PERIOD_NS) > 0 ?
      (IRQ_PULSE_NS / CLK_PERIOD_NS) : 1);
   localparam logic [1:0] IRQ_WIN_CYC = 2'h1;
   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // phase sequencer states, gray along idle-delay-train
   typedef enum logic [1:0] {
      PH_IDLE = 2'b00,
      PH_DELAY = 2'b01,
      PH_TRAIN = 2'b11
   } phase_state_t;
endpackage

// ---- core/triac_burst_phase_driver.sv ----
// What this block does
// - burst on mains clock emits 2*(N+1)*level pulses per window
// - new level applies from next window
// - burst pulses timed from both crossing edges
// - first pulse at crossing, later ones centred
// - burst pulse length is width word cycles
// - polarity change reaches output at once
// - width and prescaler latched while held reset
// - negative gate pulses start at crossing edges
// - irq_select picks burst interrupt source
// - window edge interrupts last one cycle
// - negative polarity fires irq on falling edge
// - mode field selects pwm, burst, phase
// - phase delay is level*(N+1) clock cycles
// - single sync uses rise pin for both
// - eight 50 percent pulses after delay
// - phase width changes only after reset
// - phase interrupt sources, each 50 ns
// - zero width keeps output idle, irq still
// - clock_source_sel picks master or mains clock
// - gate_polarity selects positive or negative pulses
// - burst window is 255 prescaler periods
// - enable low resets and tristates output
`timescale 1ns/10ps
module triac_burst_phase_driver (
   // clock and reset
   input wire logic I_CLK,
   input wire logic I_ARST_N,
   // zero-crossing inputs
   input wire logic I_ZC_RISE,
   input wire logic I_ZC_FALL,
   // gate output pin
   output logic O_GATE_OUT,
   output logic O_GATE_OE,
   output logic O_IRQ,
   // axi4-lite write address
   input wire logic [7:0] I_AWADDR,
   input wire logic I_AWVALID,
   output logic O_AWREADY,
   // axi4-lite write data
   input wire logic [31:0] I_WDATA,
   input wire logic [3:0] I_WSTRB,
   input wire logic I_WVALID,
   output logic O_WREADY,
   // axi4-lite write response
   output logic [1:0] O_BRESP,
   output logic O_BVALID,
   input wire logic I_BREADY,
   // axi4-lite read address
   input wire logic [7:0] I_ARADDR,
   input wire logic I_ARVALID,
   output logic O_ARREADY,
   // axi4-lite read data
   output logic [31:0] O_RDATA,
   output logic [1:0] O_RRESP,
   output logic O_RVALID,
   input wire logic I_RREADY
);
   // complete module state
   typedef struct packed {
      logic zr_meta;
      logic zr_sync;
      logic zr_prev;
      logic zf_meta;
      logic zf_sync;
      logic zfs_prev;
      logic [7:0] ctrl;
      logic [7:0] pw_hi;
      logic [7:0] pw_lo;
      logic [7:0] irq_cfg;
      logic [7:0] level;
      logic [15:0] presc;
      logic [15:0] tp_lat;
      logic [15:0] presc_lat;
      logic [15:0] psc_cnt;
      logic [7:0] win_cnt;
      logic [7:0] level_act;
      logic win_on;
      logic win_fired;
      logic [23:0] half_cnt;
      logic [23:0] half_len;
      logic fire;
      logic [15:0] fire_cnt;
      triac_drv_pkg::phase_state_t ph_state;
      logic [15:0] dly_sub;
      logic [7:0] dly_cnt;
      logic [3:0] train_idx;
      logic [1:0] irq_cnt;
      logic irq;
      logic gate_out;
      logic gate_oe;
      logic aw_got;
      logic [7:0] awaddr;
      logic w_got;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } state_t;

   state_t s; // registered state
   state_t next_s; // next state
   logic [1:0] rst_sync; // reset release chain
   logic rst_n; // synchronised reset
   logic enabled; // peripheral out of reset
   logic running; // counters advancing
   logic [1:0] mode; // working mode
   logic [2:0] irq_sel; // interrupt source
   logic fall_src; // crossing source for falling edges
   logic ev_rise; // rising edge on rise pin
   logic ev_rise_fall; // falling edge on rise pin
   logic ev_fall; // falling edge on fall source
   logic zc; // any zero crossing
   logic ptick; // prescaler output period
   logic [15:0] half_tp; // half of the pulse length

   // byte-lane merge of a write into a register
   function automatic logic [7:0] lane_merge(input logic [7:0] old, input logic [7:0] data,
                                             input logic strb);
      lane_merge = strb ? data : old;
   endfunction

   // release the asynchronous reset through two flops
   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   // next-state logic for the whole block
   always_comb begin
      next_s = s;
      enabled = s.ctrl[triac_drv_pkg::EN_BIT];
      running = enabled & s.ctrl[triac_drv_pkg::RUN_BIT];
      mode = s.ctrl[triac_drv_pkg::MODE_HI:triac_drv_pkg::MODE_LO];
      irq_sel = s.irq_cfg[triac_drv_pkg::IRQ_SEL_HI:triac_drv_pkg::IRQ_SEL_LO];
      ptick = 1'b0;
      half_tp = {1'b0, s.tp_lat[15:1]};
      // two-flop synchronisers, edges from synced copies
      next_s.zr_meta = I_ZC_RISE;
      next_s.zr_sync = s.zr_meta;
      next_s.zf_meta = I_ZC_FALL;
      next_s.zf_sync = s.zf_meta;
      next_s.zr_prev = s.zr_sync;
      // single sync feeds rise pin as fall source
      fall_src = s.ctrl[triac_drv_pkg::SSEL_BIT] ? s.zr_sync : s.zf_sync;
      next_s.zfs_prev = fall_src;
      // crossings are rise-pin rising, fall-source falling
      ev_rise = s.zr_sync & ~s.zr_prev;
      ev_rise_fall = ~s.zr_sync & s.zr_prev;
      ev_fall = ~fall_src & s.zfs_prev;
      zc = ev_rise | ev_fall;
      // interrupt pulse countdown
      if (s.irq_cnt != 2'h0) begin
         next_s.irq_cnt = s.irq_cnt - 2'h1;
      end

      if (!enabled) begin
         // held in reset, latch fixed settings
         // width and prescaler captured only here
         next_s.tp_lat = {s.pw_hi, s.pw_lo};
         next_s.presc_lat = s.presc;
         next_s.psc_cnt = 16'h0000;
         next_s.win_cnt = 8'h00;
         next_s.level_act = s.level;
         next_s.win_on = 1'b0;
         next_s.win_fired = 1'b0;
         // saturated, so a half cut short by the enable never sets centring
         next_s.half_cnt = 24'hffffff;
         next_s.half_len = 24'h000000;
         next_s.fire = 1'b0;
         next_s.fire_cnt = 16'h0000;
         next_s.ph_state = triac_drv_pkg::PH_IDLE;
         next_s.dly_sub = 16'h0000;
         next_s.dly_cnt = 8'h00;
         next_s.train_idx = 4'h0;
         next_s.irq_cnt = 2'h0;
      end else if (running && mode == triac_drv_pkg::MODE_BURST) begin
         // prescaler clock is master or mains edge
         if (!s.ctrl[triac_drv_pkg::CKSEL_BIT] || ev_rise) begin
            if (s.psc_cnt == s.presc_lat) begin
               next_s.psc_cnt = 16'h0000;
               ptick = 1'b1;
            end else begin
               next_s.psc_cnt = s.psc_cnt + 16'h0001;
            end
         end
         if (ptick) begin
            if (s.win_cnt == triac_drv_pkg::WIN_LAST) begin
               next_s.win_cnt = 8'h00;
               // level taken only at window start
               next_s.level_act = s.level;
            end else begin
               next_s.win_cnt = s.win_cnt + 8'h01;
            end
         end
         // on for level periods, 2*(N+1) crossings each on mains clock
         next_s.win_on = next_s.win_cnt < next_s.level_act;
         if (!next_s.win_on) begin
            next_s.win_fired = 1'b0;
         end
         if (next_s.win_on && !s.win_on && (irq_sel == triac_drv_pkg::IRQ_RISE ||
             irq_sel == triac_drv_pkg::IRQ_BOTH)) begin
            next_s.irq_cnt = triac_drv_pkg::IRQ_WIN_CYC;
         end
         if (!next_s.win_on && s.win_on && (irq_sel == triac_drv_pkg::IRQ_FALL ||
             irq_sel == triac_drv_pkg::IRQ_BOTH)) begin
            next_s.irq_cnt = triac_drv_pkg::IRQ_WIN_CYC;
         end
         // half-period measurement between crossings
         if (zc) begin
            next_s.half_len = s.half_cnt;
            next_s.half_cnt = 24'h000000;
         end else if (s.half_cnt != 24'hffffff) begin
            next_s.half_cnt = s.half_cnt + 24'h000001;
         end
         // pulse held for width word cycles
         if (s.fire) begin
            if (s.fire_cnt <= 16'h0001) begin
               next_s.fire = 1'b0;
               // negative polarity flags the falling edge
               if (s.ctrl[triac_drv_pkg::POL_BIT] && irq_sel == triac_drv_pkg::IRQ_PULSE) begin
                  next_s.irq_cnt = triac_drv_pkg::IRQ_PULSE_CYC;
               end
            end else begin
               next_s.fire_cnt = s.fire_cnt - 16'h0001;
            end
         end else if (s.win_on && s.tp_lat != 16'h0000) begin
            // first at crossing, later half a pulse early
            // negative gate starts only at crossing edges
            if (zc || (s.win_fired && !s.ctrl[triac_drv_pkg::POL_BIT] &&
                s.half_len > {8'h00, half_tp} &&
                s.half_cnt == s.half_len - {8'h00, half_tp})) begin
               next_s.fire = 1'b1;
               next_s.fire_cnt = s.tp_lat;
               next_s.win_fired = 1'b1;
               // pulse source flags each rising pulse
               if (!s.ctrl[triac_drv_pkg::POL_BIT] && irq_sel == triac_drv_pkg::IRQ_PULSE) begin
                  next_s.irq_cnt = triac_drv_pkg::IRQ_PULSE_CYC;
               end
            end
         end
      end else if (running && mode[1]) begin
         // phase-mode crossing interrupts, 50 ns each
         if ((ev_rise && (irq_sel == triac_drv_pkg::IRQ_RISE ||
              irq_sel == triac_drv_pkg::IRQ_BOTH)) ||
             (ev_fall && irq_sel == triac_drv_pkg::IRQ_FALL) ||
             (ev_rise_fall && irq_sel == triac_drv_pkg::IRQ_BOTH)) begin
            next_s.irq_cnt = triac_drv_pkg::IRQ_PULSE_CYC;
         end
         if (zc) begin
            // each half period restarts the delay
            next_s.ph_state = triac_drv_pkg::PH_DELAY;
            next_s.dly_sub = 16'h0000;
            next_s.dly_cnt = 8'h00;
            next_s.level_act = s.level;
            next_s.fire = 1'b0;
            next_s.train_idx = 4'h0;
         end else begin
            unique case (s.ph_state)
               triac_drv_pkg::PH_IDLE: begin
                  next_s.fire = 1'b0;
               end
               triac_drv_pkg::PH_DELAY: begin
                  // level steps of (N+1) master cycles
                  if (s.dly_cnt == s.level_act) begin
                     // zero width stays idle, irq still raised
                     next_s.ph_state = (s.tp_lat == 16'h0000) ? triac_drv_pkg::PH_IDLE :
                        triac_drv_pkg::PH_TRAIN;
                     next_s.fire = (s.tp_lat != 16'h0000);
                     next_s.fire_cnt = s.tp_lat;
                     next_s.train_idx = 4'h0;
                     if (irq_sel == triac_drv_pkg::IRQ_PULSE) begin
                        next_s.irq_cnt = triac_drv_pkg::IRQ_PULSE_CYC;
                     end
                  end else if (s.dly_sub == s.presc_lat) begin
                     next_s.dly_sub = 16'h0000;
                     next_s.dly_cnt = s.dly_cnt + 8'h01;
                  end else begin
                     next_s.dly_sub = s.dly_sub + 16'h0001;
                  end
               end
               triac_drv_pkg::PH_TRAIN: begin
                  // sixteen equal halves make eight pulses
                  if (s.fire_cnt <= 16'h0001) begin
                     next_s.fire_cnt = s.tp_lat;
                     next_s.train_idx = s.train_idx + 4'h1;
                     next_s.fire = ~s.fire;
                     if (s.train_idx == triac_drv_pkg::TRAIN_LAST) begin
                        next_s.ph_state = triac_drv_pkg::PH_IDLE;
                        next_s.fire = 1'b0;
                     end
                  end else begin
                     next_s.fire_cnt = s.fire_cnt - 16'h0001;
                  end
               end
               default: begin
                  next_s.ph_state = triac_drv_pkg::PH_IDLE;
                  next_s.fire = 1'b0;
               end
            endcase
         end
      end else if (enabled && !mode[1] && mode != triac_drv_pkg::MODE_BURST) begin
         // plain pwm lives elsewhere, gate idle
         next_s.fire = 1'b0;
      end

      // register bus: write address and data in either order
      if (I_AWVALID && s.awready) begin
         next_s.aw_got = 1'b1;
         next_s.awaddr = I_AWADDR;
      end
      if (I_WVALID && s.wready) begin
         next_s.w_got = 1'b1;
         next_s.wdata = I_WDATA;
         next_s.wstrb = I_WSTRB;
      end
      if (s.bvalid && I_BREADY) begin
         next_s.bvalid = 1'b0;
      end
      // perform the write once both halves are held
      if (s.aw_got && s.w_got && !s.bvalid) begin
         next_s.aw_got = 1'b0;
         next_s.w_got = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = triac_drv_pkg::RESP_OKAY;
         unique case (s.awaddr)
            triac_drv_pkg::ADDR_CONTROL: begin
               next_s.ctrl = lane_merge(s.ctrl, s.wdata[7:0], s.wstrb[0]);
            end
            triac_drv_pkg::ADDR_WIDTH_HIGH: begin
               next_s.pw_hi = lane_merge(s.pw_hi, s.wdata[7:0], s.wstrb[0]);
            end
            triac_drv_pkg::ADDR_WIDTH_LOW: begin
               next_s.pw_lo = lane_merge(s.pw_lo, s.wdata[7:0], s.wstrb[0]);
            end
            triac_drv_pkg::ADDR_IRQ_CONFIG: begin
               next_s.irq_cfg = lane_merge(s.irq_cfg, s.wdata[7:0], s.wstrb[0]);
            end
            triac_drv_pkg::ADDR_LEVEL: begin
               next_s.level = lane_merge(s.level, s.wdata[7:0], s.wstrb[0]);
            end
            triac_drv_pkg::ADDR_PRESCALER: begin
               next_s.presc = {lane_merge(s.presc[15:8], s.wdata[15:8], s.wstrb[1]),
                               lane_merge(s.presc[7:0], s.wdata[7:0], s.wstrb[0])};
            end
            triac_drv_pkg::ADDR_STATUS: begin
               next_s.bresp = triac_drv_pkg::RESP_OKAY;
            end
            default: begin
               next_s.bresp = triac_drv_pkg::RESP_SLVERR;
            end
         endcase
      end
      // read channel
      if (s.rvalid && I_RREADY) begin
         next_s.rvalid = 1'b0;
      end
      if (I_ARVALID && s.arready) begin
         next_s.rvalid = 1'b1;
         next_s.rresp = triac_drv_pkg::RESP_OKAY;
         unique case (I_ARADDR)
            triac_drv_pkg::ADDR_CONTROL: next_s.rdata = {24'h000000, s.ctrl};
            triac_drv_pkg::ADDR_WIDTH_HIGH: next_s.rdata = {24'h000000, s.pw_hi};
            triac_drv_pkg::ADDR_WIDTH_LOW: next_s.rdata = {24'h000000, s.pw_lo};
            triac_drv_pkg::ADDR_IRQ_CONFIG: next_s.rdata = {24'h000000, s.irq_cfg};
            triac_drv_pkg::ADDR_LEVEL: next_s.rdata = {24'h000000, s.level};
            triac_drv_pkg::ADDR_PRESCALER: next_s.rdata = {16'h0000, s.presc};
            triac_drv_pkg::ADDR_STATUS: begin
               next_s.rdata = {8'h00, s.win_cnt, s.level_act, 2'h0, s.ph_state,
                               s.irq, s.gate_out, s.fire, s.win_on};
            end
            default: begin
               next_s.rdata = 32'h00000000;
               next_s.rresp = triac_drv_pkg::RESP_SLVERR;
            end
         endcase
      end
      // ready flags computed from the coming state
      next_s.awready = ~next_s.aw_got & ~next_s.bvalid;
      next_s.wready = ~next_s.w_got & ~next_s.bvalid;
      next_s.arready = ~next_s.rvalid;

      // polarity applied straight to the output
      // polarity 1 inverts the gate pulses
      next_s.gate_out = next_s.fire ^ next_s.ctrl[triac_drv_pkg::POL_BIT];
      // output enabled only when peripheral set
      next_s.gate_oe = next_s.ctrl[triac_drv_pkg::EN_BIT];
      next_s.irq = next_s.irq_cnt != 2'h0;
   end

   // state register
   always_ff @(posedge I_CLK or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
         s.ctrl <= triac_drv_pkg::RST_CONTROL;
         s.pw_hi <= triac_drv_pkg::RST_WIDTH;
         s.pw_lo <= triac_drv_pkg::RST_WIDTH;
         s.irq_cfg <= triac_drv_pkg::RST_IRQ_CONFIG;
         s.level <= triac_drv_pkg::RST_LEVEL;
         s.presc <= triac_drv_pkg::RST_PRESCALER;
         s.ph_state <= triac_drv_pkg::PH_IDLE;
      end else begin
         s <= next_s;
      end
   end

   // outputs straight from the state register
   assign O_GATE_OUT = s.gate_out;
   assign O_GATE_OE = s.gate_oe;
   assign O_IRQ = s.irq;
   assign O_AWREADY = s.awready;
   assign O_WREADY = s.wready;
   assign O_BRESP = s.bresp;
   assign O_BVALID = s.bvalid;
   assign O_ARREADY = s.arready;
   assign O_RDATA = s.rdata;
   assign O_RRESP = s.rresp;
   assign O_RVALID = s.rvalid;

   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!rst_n);

   a_oe_follows_enable: assert property (
      !s.ctrl[triac_drv_pkg::EN_BIT] |-> !O_GATE_OE ##1 !s.fire)
      else $error("gate enabled while peripheral held reset");
   a_pol_immediate: assert property (
      s.ctrl[triac_drv_pkg::POL_BIT] != $past(s.ctrl[triac_drv_pkg::POL_BIT]) &&
      s.fire == $past(s.fire) |-> O_GATE_OUT != $past(O_GATE_OUT))
      else $error("polarity change did not reach output");
   a_burst_len_load: assert property (
      $rose(s.fire) && mode == triac_drv_pkg::MODE_BURST |-> s.fire_cnt == s.tp_lat)
      else $error("burst pulse not loaded with width word");
   a_win_irq_single: assert property (
      $rose(s.win_on) && irq_sel == triac_drv_pkg::IRQ_RISE && s.irq_cnt == 2'h1
      |-> O_IRQ ##1 !O_IRQ)
      else $error("window interrupt not one cycle");
   a_phase_irq_len: assert property (
      $rose(O_IRQ) && mode[1] |-> ##1 O_IRQ)
      else $error("phase interrupt shorter than 50 ns");
   a_level_at_window: assert property (
      running && mode == triac_drv_pkg::MODE_BURST && $changed(s.level_act)
      |-> s.win_cnt == 8'h00)
      else $error("drive level applied inside a window");
   a_win_count_range: assert property (
      s.win_cnt != 8'hff)
      else $error("window counter beyond 255 periods");
   a_zero_width_idle: assert property (
      enabled && mode[1] && s.tp_lat == 16'h0000 |-> !s.fire)
      else $error("zero width still fired the gate");
   a_delay_irq: assert property (
      running && mode[1] && s.ph_state == triac_drv_pkg::PH_DELAY &&
      s.dly_cnt == s.level_act && !zc && irq_sel == triac_drv_pkg::IRQ_PULSE
      |=> O_IRQ ##1 O_IRQ)
      else $error("no interrupt at end of phase delay");
endmodule

// ---- tb/mains_zc_model.sv ----
`timescale 1ns/10ps
module mains_zc_model #(
   parameter int HALF_NS = 40000
) (
   // crossing detector outputs
   output logic o_zc_rise,
   output logic o_zc_fall
);
   // square wave from the detector, one edge per mains crossing
   initial begin
      o_zc_rise = 1'b0;
      o_zc_fall = 1'b0;
      forever begin
         #(HALF_NS);
         o_zc_rise = ~o_zc_rise;
         o_zc_fall = o_zc_rise;
      end
   end
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
   // clock, reset and pins
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic zc_rise, zc_fall, gate, oe, irq;
   // register bus
   logic [7:0] aw_addr = 8'h00, ar_addr = 8'h00;
   logic [31:0] w_data = 32'h0, r_data;
   logic aw_valid = 1'b0, w_valid = 1'b0, b_ready = 1'b0, ar_valid = 1'b0, r_ready = 1'b0;
   logic aw_ready, w_ready, b_valid, ar_ready, r_valid;
   logic [1:0] b_resp, r_resp, b_last;
   int fail_count = 0;
   int compares = 0;
   // 40 MHz master clock
   always #12.5 clk = ~clk;
   mains_zc_model #(.HALF_NS(40000)) mains_zc_model_i (.o_zc_rise(zc_rise), .o_zc_fall(zc_fall));
   triac_burst_phase_driver triac_burst_phase_driver_i (.I_CLK(clk), .I_ARST_N(arst_n),
      .I_ZC_RISE(zc_rise), .I_ZC_FALL(zc_fall), .O_GATE_OUT(gate), .O_GATE_OE(oe),
      .O_IRQ(irq), .I_AWADDR(aw_addr), .I_AWVALID(aw_valid), .O_AWREADY(aw_ready),
      .I_WDATA(w_data), .I_WSTRB(4'hf), .I_WVALID(w_valid), .O_WREADY(w_ready),
      .O_BRESP(b_resp), .O_BVALID(b_valid), .I_BREADY(b_ready), .I_ARADDR(ar_addr),
      .I_ARVALID(ar_valid), .O_ARREADY(ar_ready), .O_RDATA(r_data), .O_RRESP(r_resp),
      .O_RVALID(r_valid), .I_RREADY(r_ready));
   // verdict and end of run
   task automatic stop_test;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // compare and count
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // a spent wait bound ends the run
   task automatic lim(input int n, input int m);
      if (n >= m) begin
         chk(n, 0);
         stop_test();
      end
   endtask
   // one write, both halves offered together
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      aw_addr <= a;
      w_data <= d;
      aw_valid <= 1'b1;
      w_valid <= 1'b1;
      b_ready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (aw_valid && aw_ready) aw_valid <= 1'b0;
         if (w_valid && w_ready) w_valid <= 1'b0;
         if (b_valid && b_ready) begin
            b_ready <= 1'b0;
            b_last = b_resp;
         end
      end while ((aw_valid || w_valid || b_ready) && n < 40);
      lim(n, 40);
   endtask
   // one read, data taken at the handshake edge
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      ar_addr <= a;
      ar_valid <= 1'b1;
      r_ready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (ar_valid && ar_ready) ar_valid <= 1'b0;
         if (r_valid && r_ready) begin
            d = r_data;
            r = r_resp;
            r_ready <= 1'b0;
         end
      end while ((ar_valid || r_ready) && n < 40);
      lim(n, 40);
   endtask
   // cyc clock cycles from a rising crossing: active edges, active cycles, irqs
   task automatic measure(input logic gate_polarity, input int cyc, input logic [31:0] ctl,
         output int act, output int hi, output int ni, output int first);
      int n;
      logic pa, pi, a, q;
      act = 0;
      hi = 0;
      ni = 0;
      first = -1;
      pa = 1'b0;
      pi = 1'b0;
      n = 0;
      while (zc_rise !== 1'b0 && n < 4000) begin
         @(posedge clk);
         n++;
      end
      while (zc_rise !== 1'b1 && n < 4000) begin
         @(posedge clk);
         n++;
      end
      lim(n, 4000);
      // optional control write just after the rising crossing
      if (ctl != 32'h0) wr(triac_drv_pkg::ADDR_CONTROL, ctl);
      for (int i = 0; i < cyc; i++) begin
         @(posedge clk);
         // an unknown level counts as active, so it cannot slip through
         a = (gate ^ gate_polarity) !== 1'b0;
         q = irq !== 1'b0;
         if (a && !pa) act++;
         if (a && first < 0) first = i;
         hi += a;
         if (q && !pi) ni++;
         pa = a;
         pi = q;
      end
   endtask
   // main sequence
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      int w, lv, act, hi, ni, first;
      void'($urandom(32'h96916e1d));
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      repeat (4) @(posedge clk);
      // reset values of control and width bytes, then an unmapped place
      for (int i = 0; i < 3; i++) begin
         rd(8'(4 * i), d, r);
         chk(d, 32'h0);
      end
      rd(8'h1c, d, r);
      chk(32'(r), 32'(triac_drv_pkg::RESP_SLVERR));
      wr(8'h1c, 32'h0);
      chk(32'(b_last), 32'(triac_drv_pkg::RESP_SLVERR));
      // random width and level, prescaler of one
      w = 4 + $urandom % 12;
      lv = 1 + $urandom % 8;
      wr(triac_drv_pkg::ADDR_WIDTH_HIGH, 32'h0);
      chk(32'(b_last), 32'(triac_drv_pkg::RESP_OKAY));
      wr(triac_drv_pkg::ADDR_WIDTH_LOW, 32'(w));
      rd(triac_drv_pkg::ADDR_WIDTH_LOW, d, r);
      chk(d, 32'(w));
      wr(triac_drv_pkg::ADDR_PRESCALER, 32'h1);
      wr(triac_drv_pkg::ADDR_LEVEL, 32'(lv));
      wr(triac_drv_pkg::ADDR_IRQ_CONFIG, 32'(triac_drv_pkg::IRQ_PULSE) << 3);
      // phase mode, master clock, running, positive pulses
      wr(triac_drv_pkg::ADDR_CONTROL, 32'ha8);
      repeat (2) @(posedge clk);
      chk(32'(oe), 32'h1);
      measure(1'b0, 3200, 32'h0, act, hi, ni, first);
      chk(act, 16);
      chk(hi, 16 * w);
      chk(ni, 2);
      chk(32'(first >= 2 * lv && first <= 2 * lv + 8), 32'h1);
      // polarity turned round while running
      wr(triac_drv_pkg::ADDR_CONTROL, 32'ha9);
      measure(1'b1, 3200, 32'h0, act, hi, ni, first);
      chk(act, 16);
      chk(hi, 16 * w);
      // zero width applied through a peripheral reset
      wr(triac_drv_pkg::ADDR_CONTROL, 32'h29);
      repeat (2) @(posedge clk);
      chk(32'(oe), 32'h0);
      wr(triac_drv_pkg::ADDR_WIDTH_LOW, 32'h0);
      wr(triac_drv_pkg::ADDR_CONTROL, 32'ha9);
      measure(1'b1, 3200, 32'h0, act, hi, ni, first);
      chk(hi, 0);
      chk(ni, 2);
      // burst on the mains clock with single sync, window opened after a rise
      wr(triac_drv_pkg::ADDR_CONTROL, 32'h74);
      wr(triac_drv_pkg::ADDR_WIDTH_LOW, 32'(w));
      wr(triac_drv_pkg::ADDR_PRESCALER, 32'h0);
      measure(1'b0, 3200 * lv + 24, 32'hf4, act, hi, ni, first);
      chk(act, 2 * (0 + 1) * lv);
      chk(hi, 2 * lv * w);
      chk(ni, 2 * lv);
      stop_test();
   end
endmodule
